// file: rotate_subtract_sleep_exec_test.sv
/*
 * self-checking bench for the rotate / subtract / sleep execution block.
 * assumes the register map and opcodes of rsse_regs.vh; the bench is the
 * only AXI4-Lite master.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rsse_regs.vh"

module rotate_subtract_sleep_exec_test;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic aclk, aresetn;
    logic [31:0] awaddr, wdata, araddr;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, osc_stop, wdt_clear;
    logic wake_in = 1'b0;
    logic [1:0] bresp, rresp, last_resp;
    logic [31:0] rdata, last_data;
    int bad_count = 0, cmp_count = 0, clr_pulses = 0;

    rsse_exec dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wake_in(wake_in), .osc_stop(osc_stop), .wdt_clear(wdt_clear));

    // clock, 10 ns period
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // count watchdog clear pulses to prove exactly one per sleep
    always @(posedge aclk)
        if (wdt_clear === 1'b1) clr_pulses++;

    // ****************************************************************
    // bus tasks
    // ****************************************************************
    // address and data offered together, each released when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        // ready held back a cycle so the response must stand on its own
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        last_resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        last_data = rdata;
        last_resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // read a register, compare the masked bits
    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] m,
        input logic [31:0] e);
        rd(a);
        chk(nm, e, last_data & m);
    endtask

    function automatic logic [31:0] insn(input logic [2:0] op, input logic dst,
        input logic [6:0] fa, input logic [7:0] k);
        insn = {8'h00, k, 1'b0, fa, 4'h0, dst, op};
    endfunction

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_rot_left;
        wr(`RSSE_OFF_FSEL, 32'h00000005);
        wr(`RSSE_OFF_FDATA, 32'h000000E6);
        wr(`RSSE_OFF_STATUS, 32'h00000006); // half-carry and zero set, carry clear
        wr(`RSSE_OFF_INSN, insn(`RSSE_OP_ROT_LEFT, 1'b0, 7'h05, 8'h00));
        rd_chk("rl accum", `RSSE_OFF_ACCUM, 32'hFF, 32'hCC);
        rd_chk("rl flags", `RSSE_OFF_STATUS, 32'h07, 32'h07);
        rd_chk("rl file kept", `RSSE_OFF_FDATA, 32'hFF, 32'hE6);
        wr(`RSSE_OFF_INSN, insn(`RSSE_OP_ROT_LEFT, 1'b1, 7'h05, 8'h00));
        rd_chk("rl file", `RSSE_OFF_FDATA, 32'hFF, 32'hCD);
        rd_chk("rl accum kept", `RSSE_OFF_ACCUM, 32'hFF, 32'hCC);
    endtask

    task automatic t_rot_right;
        wr(`RSSE_OFF_FSEL, 32'h00000009);
        wr(`RSSE_OFF_FDATA, 32'h00000001);
        wr(`RSSE_OFF_STATUS, 32'h00000000);
        wr(`RSSE_OFF_INSN, insn(`RSSE_OP_ROT_RIGHT, 1'b1, 7'h09, 8'h00));
        rd_chk("rr file", `RSSE_OFF_FDATA, 32'hFF, 32'h00);
        rd_chk("rr carry", `RSSE_OFF_STATUS, 32'h07, 32'h01);
        wr(`RSSE_OFF_INSN, insn(`RSSE_OP_ROT_RIGHT, 1'b0, 7'h09, 8'h00));
        rd_chk("rr accum", `RSSE_OFF_ACCUM, 32'hFF, 32'h80);
        rd_chk("rr carry out", `RSSE_OFF_STATUS, 32'h07, 32'h00);
    endtask

    // equal, borrow, nibble borrow only, full range
    task automatic t_subtract;
        logic [7:0] w_tab [4] = '{8'h05, 8'h06, 8'h18, 8'h00};
        logic [7:0] k_tab [4] = '{8'h05, 8'h05, 8'h21, 8'hFF};
        logic [7:0] res;
        logic [2:0] fl;
        for (int i = 0; i < 4; i++)
        begin
            res = k_tab[i] - w_tab[i];
            fl = {res == 8'h00, w_tab[i][3:0] <= k_tab[i][3:0], w_tab[i] <= k_tab[i]};
            wr(`RSSE_OFF_ACCUM, {24'h0, w_tab[i]});
            wr(`RSSE_OFF_INSN, insn(`RSSE_OP_LIT_MINUS, 1'b1, 7'h00, k_tab[i]));
            rd_chk("sub accum", `RSSE_OFF_ACCUM, 32'hFF, {24'h0, res});
            rd_chk("sub flags", `RSSE_OFF_STATUS, 32'h07, {29'h0, fl});
        end
    endtask

    task automatic t_sleep;
        wr(`RSSE_OFF_INSN, insn(`RSSE_OP_SLEEP, 1'b0, 7'h00, 8'h00));
        chk("osc_stop on", 32'h1, {31'h0, osc_stop});
        rd_chk("sleep status", `RSSE_OFF_STATUS, 32'h38, 32'h30);
        rd_chk("wdog cleared", `RSSE_OFF_WDOG, 32'hFFFF, 32'h0);
        chk("clear pulses", 32'h1, clr_pulses);
        // asleep: instructions are stored but must not run
        wr(`RSSE_OFF_ACCUM, 32'h00000011);
        wr(`RSSE_OFF_INSN, insn(`RSSE_OP_LIT_MINUS, 1'b0, 7'h00, 8'h20));
        rd_chk("no exec asleep", `RSSE_OFF_ACCUM, 32'hFF, 32'h11);
        rd_chk("insn kept", `RSSE_OFF_INSN, 32'hFFFFFFFF,
            insn(`RSSE_OP_LIT_MINUS, 1'b0, 7'h00, 8'h20));
        wake_in <= 1'b1;
        @(posedge aclk);
        wake_in <= 1'b0;
        @(posedge aclk);
        chk("osc_stop off", 32'h0, {31'h0, osc_stop});
        rd_chk("wake status", `RSSE_OFF_STATUS, 32'h38, 32'h10);
        // a no-op leaves the accumulator alone, then execution resumes
        wr(`RSSE_OFF_INSN, insn(`RSSE_OP_NOP, 1'b0, 7'h00, 8'h00));
        rd_chk("nop accum", `RSSE_OFF_ACCUM, 32'hFF, 32'h11);
        wr(`RSSE_OFF_INSN, insn(`RSSE_OP_LIT_MINUS, 1'b0, 7'h00, 8'h20));
        rd_chk("exec after wake", `RSSE_OFF_ACCUM, 32'hFF, 32'h0F);
    endtask

    task automatic t_unmapped;
        wr(32'h00000018, 32'h000000AA);
        chk("unmapped bresp", {30'h0, `RSSE_RESP_SLVERR}, {30'h0, last_resp});
        rd(32'h00000018);
        chk("unmapped rresp", {30'h0, `RSSE_RESP_SLVERR}, {30'h0, last_resp});
        chk("unmapped rdata", 32'h0, last_data);
    endtask

    // ****************************************************************
    // verdict
    // ****************************************************************
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles of the run
    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        report_and_stop;
    end

    initial
    begin
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk("reset status", `RSSE_OFF_STATUS, 32'h3F, 32'h18);
        t_rot_left;
        t_rot_right;
        t_subtract;
        t_sleep;
        t_unmapped;
        report_and_stop;
    end
endmodule // rotate_subtract_sleep_exec_test

`default_nettype wire

// file: rsse_alu.v
/*
 * combinational result and flag logic for rotate-through-carry and
 * literal-minus-accumulator.
 * assumes the caller decides which flags are stored for each opcode.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rsse_regs.vh"

module rsse_alu (
    input wire [2:0] op,          // opcode
    input wire [7:0] file_val,    // addressed file register
    input wire [7:0] accum,       // accumulator
    input wire [7:0] literal,     // immediate operand
    input wire carry_in,          // current carry flag
    output reg [7:0] result,      // datapath result
    output reg carry_out,         // new carry
    output reg half_out,          // new half-carry
    output reg zero_out           // new zero
);

    // ****************************************************************
    // two's complement subtract, k + ~w + 1
    // ****************************************************************
    wire [8:0] diff_full;         // carry out in bit 8
    wire [4:0] diff_low;          // nibble borrow chain
    assign diff_full = {1'b0, literal} + {1'b0, ~accum} + 9'h001;
    assign diff_low = {1'b0, literal[3:0]} + {1'b0, ~accum[3:0]} + 5'h01;

    // ****************************************************************
    // opcode mux
    // ****************************************************************
    // flags that an opcode does not own pass through unchanged upstream
    always @*
    begin
        result = file_val;
        carry_out = carry_in;
        half_out = 1'b0;
        zero_out = 1'b0;
        case (op)
            `RSSE_OP_ROT_LEFT:
            begin
                result = {file_val[6:0], carry_in};
                carry_out = file_val[7];
            end
            `RSSE_OP_ROT_RIGHT:
            begin
                result = {carry_in, file_val[7:1]};
                carry_out = file_val[0];
            end
            `RSSE_OP_LIT_MINUS:
            begin
                result = diff_full[7:0];
                carry_out = diff_full[8];
                half_out = diff_low[4];
                zero_out = (diff_full[7:0] == `RSSE_BYTE_ZERO);
            end
            default:
            begin
                result = file_val;
            end
        endcase
    end

endmodule // rsse_alu
`default_nettype wire

// file: rsse_exec.v
/*
 * execution datapath for rotate-left/right through carry, literal minus
 * accumulator and the low-power instruction, with a 128-byte file register
 * array, behind an AXI4-Lite slave.
 * assumes one clock (aclk, 100 MHz), synchronous active-low aresetn, and a
 * master that keeps to the AXI4-Lite valid/ready rules.
 */
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "rsse_regs.vh"

module rsse_exec (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire wake_in,
    output reg osc_stop,
    output reg wdt_clear
);

    // ****************************************************************
    // helper functions
    // ****************************************************************
    // address decode, shared by the read and the write path
    function [2:0] reg_sel;
        input [31:0] addr;
        begin
            reg_sel = `RSSE_SEL_NONE;
            if (addr[31:8] == 24'h000000 && addr[1:0] == 2'h0)
            begin
                case (addr[7:0])
                    `RSSE_OFF_INSN: reg_sel = `RSSE_SEL_INSN;
                    `RSSE_OFF_ACCUM: reg_sel = `RSSE_SEL_ACCUM;
                    `RSSE_OFF_STATUS: reg_sel = `RSSE_SEL_STATUS;
                    `RSSE_OFF_WDOG: reg_sel = `RSSE_SEL_WDOG;
                    `RSSE_OFF_FSEL: reg_sel = `RSSE_SEL_FSEL;
                    `RSSE_OFF_FDATA: reg_sel = `RSSE_SEL_FDATA;
                    default: reg_sel = `RSSE_SEL_NONE;
                endcase
            end
        end
    endfunction

    // byte-lane merge of write data over an old word
    function [31:0] merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        integer i;
        begin
            merge = old_val;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (strb[i])
                    merge[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    reg [7:0] file_q [0:`RSSE_FILE_DEPTH-1]; // file register array
    reg [7:0] accum_q;            // accumulator
    reg carry_q;                  // carry flag
    reg half_q;                   // half-carry flag
    reg zero_q;                   // zero flag
    reg pd_n_q;                   // sleep_entered_flag_n
    reg to_n_q;                   // timeout_flag_n
    reg asleep_q;                 // sleep state
    reg [7:0] wdt_q;              // watchdog count
    reg [7:0] presc_q;            // watchdog prescaler
    reg [6:0] fsel_q;             // software window into the file array
    reg [31:0] insn_q;            // last instruction word accepted
    reg aw_hold_q;                // write address captured
    reg [31:0] aw_addr_q;
    reg w_hold_q;                 // write data captured
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    integer k;

    // ****************************************************************
    // AXI4-Lite handshakes
    // ****************************************************************
    // one outstanding write; address and data may arrive in either order
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire do_write;                // both halves present, perform the write
    wire [2:0] wsel;              // decoded write target
    wire [31:0] wmerged;          // write data merged over the insn word
    assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wsel = reg_sel(aw_addr_q);
    assign wmerged = merge(insn_q, w_data_q, w_strb_q);

    // ****************************************************************
    // instruction decode and datapath
    // ****************************************************************
    // an instruction word is only obeyed while awake
    wire exec_en;                 // instruction issued this cycle
    wire [2:0] op;
    wire dest;
    wire [6:0] faddr;
    wire [7:0] alu_res;
    wire alu_c;
    wire alu_dc;
    wire alu_z;
    wire [31:0] status_word;      // status as seen on the bus
    assign exec_en = do_write && wsel == `RSSE_SEL_INSN && !asleep_q;
    assign op = wmerged[`RSSE_INSN_OP];
    assign dest = wmerged[`RSSE_INSN_DEST];
    assign faddr = wmerged[`RSSE_INSN_FADDR];
    assign status_word = {26'h0000000, asleep_q, to_n_q, pd_n_q, zero_q, half_q, carry_q};

    rsse_alu u_alu (
        .op(op),
        .file_val(file_q[faddr]),
        .accum(accum_q),
        .literal(wmerged[`RSSE_INSN_LIT]),
        .carry_in(carry_q),
        .result(alu_res),
        .carry_out(alu_c),
        .half_out(alu_dc),
        .zero_out(alu_z)
    );

    wire is_rot;                  // either rotate opcode
    assign is_rot = (op == `RSSE_OP_ROT_LEFT) || (op == `RSSE_OP_ROT_RIGHT);

    // ****************************************************************
    // write path, execution and sleep
    // ****************************************************************
    // a single process owns all architectural state; software writes and
    // instruction effects never collide since both come from one write
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (k = 0; k < `RSSE_FILE_DEPTH; k = k + 1)
                file_q[k] <= `RSSE_BYTE_ZERO;
            accum_q <= `RSSE_BYTE_ZERO;
            carry_q <= 1'b0;
            half_q <= 1'b0;
            zero_q <= 1'b0;
            pd_n_q <= 1'b1;
            to_n_q <= 1'b1;
            asleep_q <= 1'b0;
            wdt_q <= `RSSE_BYTE_ZERO;
            presc_q <= `RSSE_BYTE_ZERO;
            fsel_q <= `RSSE_FADDR_ZERO;
            insn_q <= `RSSE_WORD_ZERO;
            aw_hold_q <= 1'b0;
            aw_addr_q <= `RSSE_WORD_ZERO;
            w_hold_q <= 1'b0;
            w_data_q <= `RSSE_WORD_ZERO;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RSSE_RESP_OKAY;
            osc_stop <= 1'b0;
            wdt_clear <= 1'b0;
        end
        else
        begin
            wdt_clear <= 1'b0;
            // capture address and data halves independently
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;

            // stand-in watchdog: prescaler ticks while awake, frozen asleep
            if (!asleep_q)
            begin
                presc_q <= presc_q + `RSSE_BYTE_ONE;
                if (presc_q == `RSSE_PRESC_LAST)
                    wdt_q <= wdt_q + `RSSE_BYTE_ONE;
            end

            // wake ends sleep; a sleep issued in the same cycle still wins
            if (wake_in)
            begin
                asleep_q <= 1'b0;
                osc_stop <= 1'b0;
            end

            if (do_write)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wsel == `RSSE_SEL_NONE) ? `RSSE_RESP_SLVERR : `RSSE_RESP_OKAY;
                case (wsel)
                    `RSSE_SEL_INSN:
                    begin
                        // while asleep the word is kept but not obeyed
                        insn_q <= wmerged;
                    end
                    `RSSE_SEL_ACCUM:
                    begin
                        if (w_strb_q[0])
                            accum_q <= w_data_q[7:0];
                    end
                    `RSSE_SEL_STATUS:
                    begin
                        // only the arithmetic flags are software-writable
                        if (w_strb_q[0])
                        begin
                            carry_q <= w_data_q[`RSSE_ST_CARRY];
                            half_q <= w_data_q[`RSSE_ST_HALF];
                            zero_q <= w_data_q[`RSSE_ST_ZERO];
                        end
                    end
                    `RSSE_SEL_FSEL:
                    begin
                        if (w_strb_q[0])
                            fsel_q <= w_data_q[6:0];
                    end
                    `RSSE_SEL_FDATA:
                    begin
                        if (w_strb_q[0])
                            file_q[fsel_q] <= w_data_q[7:0];
                    end
                    default:
                    begin
                        // watchdog is read-only, unmapped answers SLVERR
                    end
                endcase
            end

            // one-cycle instruction execution
            if (exec_en)
            begin
                if (is_rot)
                begin
                    carry_q <= alu_c;
                    if (dest == `RSSE_DEST_FILE)
                        file_q[faddr] <= alu_res;
                    else
                        accum_q <= alu_res;
                end
                else if (op == `RSSE_OP_LIT_MINUS)
                begin
                    accum_q <= alu_res;
                    carry_q <= alu_c;
                    half_q <= alu_dc;
                    zero_q <= alu_z;
                end
                else if (op == `RSSE_OP_SLEEP)
                begin
                    wdt_q <= `RSSE_BYTE_ZERO;
                    presc_q <= `RSSE_BYTE_ZERO;
                    wdt_clear <= 1'b1;
                    pd_n_q <= 1'b0;
                    to_n_q <= 1'b1;
                    asleep_q <= 1'b1;
                    osc_stop <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    // data registered at the address handshake, held until rready
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `RSSE_WORD_ZERO;
            s_axi_rresp <= `RSSE_RESP_OKAY;
        end
        else
        begin
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RSSE_RESP_OKAY;
                case (reg_sel(s_axi_araddr))
                    `RSSE_SEL_INSN: s_axi_rdata <= insn_q;
                    `RSSE_SEL_ACCUM: s_axi_rdata <= {24'h000000, accum_q};
                    `RSSE_SEL_STATUS: s_axi_rdata <= status_word;
                    `RSSE_SEL_WDOG: s_axi_rdata <= {16'h0000, presc_q, wdt_q};
                    `RSSE_SEL_FSEL: s_axi_rdata <= {25'h0000000, fsel_q};
                    `RSSE_SEL_FDATA: s_axi_rdata <= {24'h000000, file_q[fsel_q]};
                    default:
                    begin
                        // unmapped: zero data, slave error
                        s_axi_rdata <= `RSSE_WORD_ZERO;
                        s_axi_rresp <= `RSSE_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

endmodule // rsse_exec
`default_nettype wire

// file: rsse_exec_assertions.sv
/*
 * port-level checker for the rotate / subtract / sleep execution block.
 * assumes one clock domain (aclk) with synchronous active-low aresetn.
 */
`timescale 1ns/100ps
`default_nettype none

module rsse_exec_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wake_in,
    input wire logic osc_stop,
    input wire logic wdt_clear
);
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // sleep only begins at the edge where a write takes effect
    a_sleep_on_write: assert property ($rose(osc_stop) |-> $rose(s_axi_bvalid))
        else $error("oscillator stopped without a completing write");
    // wake-up is the only way out of sleep
    a_sleep_holds: assert property (osc_stop && !wake_in |=> osc_stop)
        else $error("oscillator restarted without wake");
    a_wake_ends_sleep: assert property (osc_stop && wake_in |=> !osc_stop)
        else $error("wake did not restart oscillator");
    // watchdog clear follows sleep entry within one cycle, as one pulse
    a_wdt_clear_follows: assert property ($rose(osc_stop) |-> ##[0:1] wdt_clear)
        else $error("watchdog clear missing after sleep entry");
    a_wdt_clear_pulse: assert property (wdt_clear |=> !wdt_clear)
        else $error("watchdog clear longer than one cycle");
    // response channels hold until taken
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not one cycle after address");
    // no new write while a response is pending
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");

    // main scenarios
    c_sleep: cover property ($rose(osc_stop));
    c_wake: cover property (osc_stop && wake_in);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // rsse_exec_checker

bind rsse_exec rsse_exec_checker u_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wake_in(wake_in),
    .osc_stop(osc_stop),
    .wdt_clear(wdt_clear)
);

`default_nettype wire

// file: rsse_regs.vh
/*
 * register map, instruction field layout, opcodes and reset values of the
 * rotate / subtract / sleep execution block.
 * assumes a 32-bit AXI4-Lite bus with word-aligned byte addresses.
 */
`ifndef RSSE_REGS_VH
`define RSSE_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define RSSE_OFF_INSN 8'h00
`define RSSE_OFF_ACCUM 8'h04
`define RSSE_OFF_STATUS 8'h08
`define RSSE_OFF_WDOG 8'h0C
`define RSSE_OFF_FSEL 8'h10
`define RSSE_OFF_FDATA 8'h14

// register select codes from the address decoder
`define RSSE_SEL_NONE 3'h0
`define RSSE_SEL_INSN 3'h1
`define RSSE_SEL_ACCUM 3'h2
`define RSSE_SEL_STATUS 3'h3
`define RSSE_SEL_WDOG 3'h4
`define RSSE_SEL_FSEL 3'h5
`define RSSE_SEL_FDATA 3'h6

// ****************************************************************
// instruction word fields
// ****************************************************************
`define RSSE_INSN_OP 2:0
`define RSSE_INSN_DEST 3
`define RSSE_INSN_FADDR 14:8
`define RSSE_INSN_LIT 23:16

// opcodes
`define RSSE_OP_NOP 3'h0
`define RSSE_OP_ROT_LEFT 3'h1
`define RSSE_OP_ROT_RIGHT 3'h2
`define RSSE_OP_LIT_MINUS 3'h3
`define RSSE_OP_SLEEP 3'h4

// destination bit values
`define RSSE_DEST_ACCUM 1'h0
`define RSSE_DEST_FILE 1'h1

// ****************************************************************
// status register bits
// ****************************************************************
`define RSSE_ST_CARRY 0
`define RSSE_ST_HALF 1
`define RSSE_ST_ZERO 2
`define RSSE_ST_PD_N 3
`define RSSE_ST_TO_N 4
`define RSSE_ST_ASLEEP 5

// ****************************************************************
// widths, sizes and reset values
// ****************************************************************
`define RSSE_FILE_DEPTH 128
`define RSSE_BYTE_ZERO 8'h00
`define RSSE_BYTE_ONE 8'h01
`define RSSE_PRESC_LAST 8'hFF
`define RSSE_WORD_ZERO 32'h00000000
`define RSSE_FADDR_ZERO 7'h00
`define RSSE_RESP_OKAY 2'h0
`define RSSE_RESP_SLVERR 2'h2

`endif
